// ===== hw/ccds_top.sv
// ccds_top: clock dividers, per-quadrant primary line muxes, glitch-free
// selectors and quadrant clock gates, configured over apb3.
// assumes all clock sources are levels sampled synchronously to i_clk.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - each divider outputs the fast clock divided by two, four or eight.
// - divided clock phase is fixed by the cycle the clear/release ends.
// - a divider's clear drops that divider's outputs at once, no clock needed.
// - after release, divider outputs restart only on a fast clock edge.
// - the selector swaps between two clocks with no glitch or runt pulse.
// - two selectors per quadrant drive primary lines six and seven.
// - eight primary lines per quadrant, each mux reaching every source.
// - software enables or disables each quadrant network; disabled lines stay still.
module ccds_top (
    input  wire logic                         i_clk,
    input  wire logic                         i_rstn,
    input  wire logic [ccds_pkg::NUM_EXT-1:0] i_clk_src,
    input  wire logic                         i_psel,
    input  wire logic                         i_penable,
    input  wire logic                         i_pwrite,
    input  wire logic [7:0]                   i_paddr,
    input  wire logic [31:0]                  i_pwdata,
    output logic      [31:0]                  o_prdata,
    output logic                              o_pready,
    output logic                              o_pslverr,
    output logic [ccds_pkg::NUM_DIV-1:0]      o_div_clk,
    output logic [31:0]                       o_quad_clk
);

    localparam int NQ = ccds_pkg::NUM_QUAD;
    localparam int NL = ccds_pkg::NUM_LINE;
    localparam int SW = ccds_pkg::SRC_SEL_W;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // pick one source by index; out-of-range indexes give a still line
    function automatic logic pick_src(input logic [ccds_pkg::NUM_SRC-1:0] src,
                                      input logic [SW-1:0]                sel);
        logic r;
        r = 1'b0;
        for (int k = 0; k < ccds_pkg::NUM_SRC; k++) begin
            if (sel == SW'(k)) begin
                r = src[k];
            end
        end
        return r;
    endfunction

    // true when the address falls in the per-quadrant mux window
    function automatic logic is_qmux(input logic [7:0] a);
        return (a >= ccds_pkg::OFS_QMUX_LO) && (a <= ccds_pkg::OFS_QMUX_HI)
               && (a[1:0] == 2'h0);
    endfunction

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [15:0] div_ctrl_q;
    logic [15:0] div_ctrl_d;
    logic [3:0]  gate_en_q;
    logic [3:0]  gate_en_d;
    logic [7:0]  sel_ctrl_q;
    logic [7:0]  sel_ctrl_d;
    logic [23:0] qmux_a_q [NQ];
    logic [23:0] qmux_a_d [NQ];
    logic [15:0] qmux_b_q [NQ];
    logic [15:0] qmux_b_d [NQ];
    logic        pready_d;
    logic        pslverr_d;
    logic [31:0] prdata_d;

    logic [ccds_pkg::NUM_DIV-1:0] div_run;
    logic [ccds_pkg::NUM_SRC-1:0] src_all;
    logic [NQ*ccds_pkg::NUM_SEL-1:0] sel_clk;
    logic [NQ*ccds_pkg::NUM_SEL-1:0] sel_on_b;
    logic [31:0] raw_line;
    logic [31:0] line_en_q;
    logic [31:0] line_en_d;
    logic [31:0] quad_clk_d;
    logic [3:0]  gate_live;

    logic        access;
    logic        take;
    logic [1:0]  qidx;

    // ------------------------------------------------------------------
    // apb slave: one wait state, write lands on the edge with pready high
    // ------------------------------------------------------------------
    assign access = i_psel & i_penable;
    assign take   = access & o_pready;
    assign qidx   = 2'((i_paddr - ccds_pkg::OFS_QMUX_LO) >> 3);

    always_comb begin
        div_ctrl_d = div_ctrl_q;
        gate_en_d  = gate_en_q;
        sel_ctrl_d = sel_ctrl_q;
        qmux_a_d   = qmux_a_q;
        qmux_b_d   = qmux_b_q;
        pready_d   = access & ~o_pready;
        pslverr_d  = 1'b0;
        prdata_d   = 32'h00000000;
        if (take && i_pwrite) begin
            case (i_paddr)
                ccds_pkg::OFS_DIV_CTRL: div_ctrl_d = i_pwdata[15:0];
                ccds_pkg::OFS_GATE_EN:  gate_en_d  = i_pwdata[3:0];
                ccds_pkg::OFS_SEL_CTRL: sel_ctrl_d = i_pwdata[7:0];
                default: begin
                    if (is_qmux(i_paddr)) begin
                        if (i_paddr[2]) begin
                            qmux_b_d[qidx] = i_pwdata[15:0];
                        end else begin
                            qmux_a_d[qidx] = i_pwdata[23:0];
                        end
                    end
                end
            endcase
        end
        if (pready_d) begin
            case (i_paddr)
                ccds_pkg::OFS_DIV_CTRL: prdata_d = {16'h0000, div_ctrl_q};
                ccds_pkg::OFS_GATE_EN:  prdata_d = {28'h0000000, gate_en_q};
                ccds_pkg::OFS_SEL_CTRL: prdata_d = {24'h000000, sel_ctrl_q};
                ccds_pkg::OFS_STATUS: begin
                    prdata_d[ccds_pkg::ST_RUN_LSB +: ccds_pkg::NUM_DIV] = div_run;
                    prdata_d[ccds_pkg::ST_SEL_LSB +: 8]  = sel_on_b;
                    prdata_d[ccds_pkg::ST_GATE_LSB +: 4] = gate_live;
                end
                default: begin
                    if (is_qmux(i_paddr)) begin
                        prdata_d = i_paddr[2] ? {16'h0000, qmux_b_q[qidx]}
                                              : {8'h00, qmux_a_q[qidx]};
                    end else begin
                        pslverr_d = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_ctrl_q <= ccds_pkg::RST_DIV_CTRL;
            gate_en_q  <= ccds_pkg::RST_GATE_EN;
            sel_ctrl_q <= ccds_pkg::RST_SEL_CTRL;
            for (int q = 0; q < NQ; q++) begin
                qmux_a_q[q] <= ccds_pkg::RST_QMUX_A;
                qmux_b_q[q] <= ccds_pkg::RST_QMUX_B;
            end
            o_pready   <= 1'b0;
            o_pslverr  <= 1'b0;
            o_prdata   <= 32'h00000000;
        end else begin
            div_ctrl_q <= div_ctrl_d;
            gate_en_q  <= gate_en_d;
            sel_ctrl_q <= sel_ctrl_d;
            qmux_a_q   <= qmux_a_d;
            qmux_b_q   <= qmux_b_d;
            o_pready   <= pready_d;
            o_pslverr  <= pslverr_d;
            o_prdata   <= prdata_d;
        end
    end

    // ------------------------------------------------------------------
    // clock dividers
    // ------------------------------------------------------------------
    for (genvar d = 0; d < ccds_pkg::NUM_DIV; d++) begin : g_div
        localparam int B = d * ccds_pkg::DIV_FIELD_W;
        ccds_divider u_div (
            .i_clk     (i_clk),
            .i_rstn    (i_rstn),
            .i_clear   (div_ctrl_q[B + ccds_pkg::DIV_CLEAR_BIT]),
            .i_release (div_ctrl_q[B + ccds_pkg::DIV_REL_BIT]),
            .i_ratio   (div_ctrl_q[B + ccds_pkg::DIV_RATIO_LSB +: 2]),
            .o_div_clk (o_div_clk[d]),
            .o_running (div_run[d])
        );
    end

    // divider outputs join the external sources as primary clock sources
    assign src_all = {o_div_clk, i_clk_src};

    // ------------------------------------------------------------------
    // per-quadrant central muxes and selectors
    // ------------------------------------------------------------------
    for (genvar q = 0; q < NQ; q++) begin : g_quad
        // lines zero to five: identical mux reaching every source
        for (genvar l = 0; l < ccds_pkg::MUX_LINES; l++) begin : g_line
            assign raw_line[q*NL + l] = pick_src(src_all, qmux_a_q[q][l*SW +: SW]);
        end
        // two selectors feed the two top lines of the quadrant
        for (genvar s = 0; s < ccds_pkg::NUM_SEL; s++) begin : g_sel
            localparam int I = q * ccds_pkg::NUM_SEL + s;
            ccds_selector u_sel (
                .i_clk   (i_clk),
                .i_rstn  (i_rstn),
                .i_src_a (pick_src(src_all, qmux_b_q[q][(2*s)*SW +: SW])),
                .i_src_b (pick_src(src_all, qmux_b_q[q][(2*s+1)*SW +: SW])),
                .i_sel   (sel_ctrl_q[I]),
                .o_clk   (sel_clk[I]),
                .o_on_b  (sel_on_b[I])
            );
            assign raw_line[q*NL + ccds_pkg::SEL_LINE0 + s] = sel_clk[I];
        end
        assign gate_live[q] = &line_en_q[q*NL +: NL];
    end

    // ------------------------------------------------------------------
    // quadrant clock gates
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            // take the new enable only while the line is low
            line_en_d[i]  = raw_line[i] ? line_en_q[i] : gate_en_q[i / NL];
            // a disabled line is held low so nothing it clocks moves
            quad_clk_d[i] = raw_line[i] & line_en_d[i];
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            line_en_q  <= 32'h00000000;
            o_quad_clk <= 32'h00000000;
        end else begin
            line_en_q  <= line_en_d;
            o_quad_clk <= quad_clk_d;
        end
    end

endmodule

// ===== hw/ccds_pkg.sv
// ccds_pkg: constants shared by the clock divider and select block.
// assumes a 32-bit apb3 register port and a single 100 MHz system clock.
package ccds_pkg;

    // ------------------------------------------------------------------
    // structure
    // ------------------------------------------------------------------
    localparam int NUM_QUAD  = 4;
    localparam int NUM_LINE  = 8;
    localparam int NUM_DIV   = 2;
    localparam int NUM_EXT   = 8;
    localparam int NUM_SRC   = NUM_EXT + NUM_DIV;
    localparam int SRC_SEL_W = 4;
    localparam int MUX_LINES = 6;
    localparam int SEL_LINE0 = 6;
    localparam int NUM_SEL   = 2;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DIV_CTRL = 8'h00;
    localparam logic [7:0] OFS_GATE_EN  = 8'h04;
    localparam logic [7:0] OFS_SEL_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_QMUX_LO  = 8'h10;
    localparam logic [7:0] OFS_QMUX_HI  = 8'h2C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int DIV_FIELD_W   = 8;
    localparam int DIV_RATIO_LSB = 0;
    localparam int DIV_CLEAR_BIT = 2;
    localparam int DIV_REL_BIT   = 3;
    localparam int ST_RUN_LSB    = 0;
    localparam int ST_SEL_LSB    = 8;
    localparam int ST_GATE_LSB   = 16;

    // ------------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_DIV_CTRL = 16'h0000;
    localparam logic [3:0]  RST_GATE_EN  = 4'hF;
    localparam logic [7:0]  RST_SEL_CTRL = 8'h00;
    localparam logic [23:0] RST_QMUX_A   = 24'h000000;
    localparam logic [15:0] RST_QMUX_B   = 16'h0000;

    localparam logic [1:0] DIV_BY2 = 2'h0;
    localparam logic [1:0] DIV_BY4 = 2'h1;
    localparam logic [1:0] DIV_BY8 = 2'h2;

    typedef enum logic [2:0] {
        SEL_FOLLOW_A = 3'h1,
        SEL_PARK     = 3'h2,
        SEL_FOLLOW_B = 3'h4
    } ccds_sel_state_t;

endpackage

// ===== hw/ccds_divider.sv
// ccds_divider: divide the fast clock by 2, 4 or 8.
// assumes i_clear comes from a flip-flop so the async clear is clean.
`timescale 1ns/1ps
module ccds_divider (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_clear,
    input  wire logic       i_release,
    input  wire logic [1:0] i_ratio,
    output logic            o_div_clk,
    output logic            o_running
);

    logic       arst_n;
    logic       running_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       out_d;

    // clear acts without the clock and forces everything low
    assign arst_n = i_rstn & ~i_clear;

    always_comb begin
        running_d = i_release;
        cnt_d     = 3'h0;
        out_d     = 1'b0;
        // counting starts at the second edge after release, fixing phase
        if (o_running) begin
            cnt_d = 3'(cnt_q + 3'h1);
            // high phase starts on the first counting edge for every ratio
            case (i_ratio)
                ccds_pkg::DIV_BY2: out_d = ~cnt_q[0];
                ccds_pkg::DIV_BY4: out_d = ~cnt_q[1];
                ccds_pkg::DIV_BY8: out_d = ~cnt_q[2];
                default:           out_d = ~cnt_q[2];
            endcase
        end
    end

    // release takes effect only on a clock edge ratio output
    always_ff @(posedge i_clk or negedge arst_n) begin
        if (!arst_n) begin
            o_running <= 1'b0;
            cnt_q     <= 3'h0;
            o_div_clk <= 1'b0;
        end else begin
            o_running <= running_d;
            cnt_q     <= cnt_d;
            o_div_clk <= out_d;
        end
    end

endmodule

// ===== hw/ccds_selector.sv
// ccds_selector: glitch-free two-way clock selector.
// assumes both source clocks are sampled levels synchronous to i_clk.
`timescale 1ns/1ps
module ccds_selector (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_src_a,
    input  wire logic i_src_b,
    input  wire logic i_sel,
    output logic      o_clk,
    output logic      o_on_b
);

    ccds_pkg::ccds_sel_state_t state_q;
    ccds_pkg::ccds_sel_state_t state_d;
    logic                      out_d;

    // leave a source only while it is low, join the new one only while it
    // is low, so no pulse is ever cut short
    always_comb begin
        state_d = state_q;
        out_d   = 1'b0;
        case (state_q)
            ccds_pkg::SEL_FOLLOW_A: begin
                if (i_sel && !i_src_a) begin
                    state_d = ccds_pkg::SEL_PARK;
                end else begin
                    out_d = i_src_a;
                end
            end
            ccds_pkg::SEL_FOLLOW_B: begin
                if (!i_sel && !i_src_b) begin
                    state_d = ccds_pkg::SEL_PARK;
                end else begin
                    out_d = i_src_b;
                end
            end
            ccds_pkg::SEL_PARK: begin
                if (i_sel && !i_src_b) begin
                    state_d = ccds_pkg::SEL_FOLLOW_B;
                end else if (!i_sel && !i_src_a) begin
                    state_d = ccds_pkg::SEL_FOLLOW_A;
                end
            end
            default: state_d = ccds_pkg::SEL_PARK;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ccds_pkg::SEL_FOLLOW_A;
            o_clk   <= 1'b0;
            o_on_b  <= 1'b0;
        end else begin
            state_q <= state_d;
            o_clk   <= out_d;
            o_on_b  <= (state_d == ccds_pkg::SEL_FOLLOW_B);
        end
    end

endmodule

// ===== tb/ccds_fabric.sv
// ccds_fabric: fabric-side model of the eight external clock sources.
// assumes one shared clock and reset with the block under test.
`timescale 1ns/1ps
module ccds_fabric (
    input  wire logic                         i_clk,
    input  wire logic                         i_rstn,
    output logic      [ccds_pkg::NUM_EXT-1:0] o_clk_src
);
    // source k has a half period of k+2 cycles, so no two look alike
    for (genvar k = 0; k < ccds_pkg::NUM_EXT; k++) begin : g_src
        logic [3:0] cnt_q;
        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                cnt_q        <= 4'h0;
                o_clk_src[k] <= 1'b0;
            end else if (cnt_q == 4'(k + 1)) begin
                cnt_q        <= 4'h0;
                o_clk_src[k] <= ~o_clk_src[k];
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// ===== tb/ccds_chk.sv
// ccds_chk: port-level assertions for ccds_top.
// assumes control register writes are snooped from the apb port.
`timescale 1ns/1ps
module ccds_chk (
    input wire logic                         i_clk,
    input wire logic                         i_rstn,
    input wire logic [ccds_pkg::NUM_EXT-1:0] i_clk_src,
    input wire logic                         i_psel,
    input wire logic                         i_penable,
    input wire logic                         i_pwrite,
    input wire logic [7:0]                   i_paddr,
    input wire logic [31:0]                  i_pwdata,
    input wire logic [31:0]                  o_prdata,
    input wire logic                         o_pready,
    input wire logic                         o_pslverr,
    input wire logic [ccds_pkg::NUM_DIV-1:0] o_div_clk,
    input wire logic [31:0]                  o_quad_clk
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic       wr, dwr, chg_d, chg_s, pd_q, ps_q;
    logic [3:0] div_q, gate_q;
    logic [2:0] hd_q, hs_q, half;
    logic [1:0] seg_q;
    logic [4:0] off_q;
    assign wr    = i_psel && i_penable && o_pready && i_pwrite;
    assign dwr   = wr && i_paddr == ccds_pkg::OFS_DIV_CTRL;
    assign chg_d = o_div_clk[0] != pd_q;
    assign chg_s = o_quad_clk[14] != ps_q;
    assign half  = (div_q[1:0] == 2'h0) ? 3'h1 : (div_q[1:0] == 2'h1) ? 3'h2 : 3'h4;
    // snooped controls and run-length counters
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_q  <= 4'h0;
            gate_q <= 4'hF;
            hd_q   <= 3'h0;
            hs_q   <= 3'h0;
            seg_q  <= 2'h0;
            off_q  <= 5'h00;
            pd_q   <= 1'b0;
            ps_q   <= 1'b0;
        end else begin
            if (dwr) div_q <= i_pwdata[3:0];
            if (wr && i_paddr == ccds_pkg::OFS_GATE_EN) gate_q <= i_pwdata[3:0];
            pd_q  <= o_div_clk[0];
            ps_q  <= o_quad_clk[14];
            hd_q  <= chg_d ? 3'h0 : (hd_q == 3'h7) ? hd_q : hd_q + 3'h1;
            hs_q  <= chg_s ? 3'h0 : (hs_q == 3'h7) ? hs_q : hs_q + 3'h1;
            seg_q <= dwr ? 2'h0 : (chg_d && seg_q != 2'h3) ? seg_q + 2'h1 : seg_q;
            off_q <= gate_q[0] ? 5'h00 : (off_q == 5'h1F) ? off_q : off_q + 5'h01;
        end
    end
    sequence s_start;
        !o_div_clk[0] ##1 !o_div_clk[0] ##1 o_div_clk[0];
    endsequence
    a_ready_wait: assert property (i_psel && i_penable && !o_pready
        && !$past(i_psel && i_penable) |=> o_pready) else $error("ready not after one wait");
    a_err_unmapped: assert property (o_pready |-> o_pslverr == (i_paddr > ccds_pkg::OFS_QMUX_HI))
        else $error("slave error does not match address");
    a_div_start: assert property (dwr && div_q[3:2] == 2'h0 && i_pwdata[3:2] == 2'h2
        |=> s_start) else $error("divider start not on fast clock edge");
    a_div_half: assert property (chg_d && seg_q >= 2'h2 |-> hd_q == half - 3'h1)
        else $error("divider half period wrong");
    a_clear_low: assert property (div_q[2] |-> !o_div_clk[0])
        else $error("divider output high under clear");
    a_stop_low: assert property (!div_q[3] [*3] |-> !o_div_clk[0])
        else $error("stopped divider toggles");
    a_gate_still: assert property (off_q == 5'h1F |-> o_quad_clk[7:0] == 8'h00)
        else $error("disabled quadrant toggles");
    a_line_follow: assert property (o_quad_clk[0] |-> $past(i_clk_src[0]))
        else $error("line high while source low");
    a_gate_rise: assert property ($rose(o_quad_clk[0]) |-> !$past(i_clk_src[0], 2))
        else $error("gate opened mid pulse");
    a_gate_fall: assert property ($fell(o_quad_clk[0]) |-> !$past(i_clk_src[0]))
        else $error("gate closed mid pulse");
    a_sel_runt: assert property (chg_s |-> hs_q != 3'h0)
        else $error("selector runt pulse");
endmodule

bind ccds_top ccds_chk u_chk (.i_clk, .i_rstn, .i_clk_src, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_div_clk, .o_quad_clk);

// ===== tb/testbench.sv
// testbench: directed scenarios for ccds_top over its apb port.
// assumes ccds_fabric supplies the free-running source clocks.
`timescale 1ns/1ps
module testbench;
    logic        i_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [7:0]  i_clk_src, s1, s2;
    logic [31:0] o_prdata, o_quad_clk;
    logic        o_pready, o_pslverr;
    logic [1:0]  o_div_clk;
    int          mismatches = 0;
    int          check_count = 0;
    int          cycles = 0;
    always #5 i_clk = ~i_clk;
    ccds_fabric u_fab (.i_clk, .i_rstn, .o_clk_src(i_clk_src));
    ccds_top uut (.i_clk, .i_rstn, .i_clk_src, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_div_clk, .o_quad_clk);
    // source history: s1 is what the edge just sampled, s2 one edge older
    always @(posedge i_clk) begin
        s2 <= s1;
        s1 <= i_clk_src;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 50);
        r = o_prdata;
        e = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic follow(input int b, input int s, input int lat, input int n);
        repeat (n) begin
            @(posedge i_clk);
            #1 chk(32'(o_quad_clk[b]), 32'(lat == 1 ? s1[s] : s2[s]));
        end
    endtask
    task automatic t_regs();
        logic [7:0]  a [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
        logic [31:0] x [5] = '{32'h0, 32'hF, 32'h0, 32'h0, 32'h0};
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, a[i], 32'h0, r, e);
            chk(r, x[i]);
            chk(32'(e), 32'h0);
        end
        apb(1'b0, 8'h30, 32'h0, r, e);
        chk(r, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b1, 8'h30, 32'hFFFF_FFFF, r, e);
        chk(32'(e), 32'h1);
        rd(ccds_pkg::OFS_STATUS, r);
        chk(r, 32'h000F_0000);
    endtask
    task automatic t_gate();
        logic [31:0] r;
        wr(ccds_pkg::OFS_GATE_EN, 32'hE);
        repeat (40) @(posedge i_clk);
        repeat (16) begin
            @(posedge i_clk);
            #1 chk(32'(o_quad_clk[7:0]), 32'h0);
        end
        rd(ccds_pkg::OFS_STATUS, r);
        chk(r, 32'h000E_0000);
        wr(ccds_pkg::OFS_GATE_EN, 32'hF);
        repeat (20) @(posedge i_clk);
        follow(0, 0, 1, 12);
    endtask
    task automatic t_div();
        int          h;
        logic [31:0] r;
        for (int d = 0; d < 2; d++) begin
            for (int k = 0; k < 4; k++) begin
                h = (k == 0) ? 1 : (k == 1) ? 2 : 4;
                wr(ccds_pkg::OFS_DIV_CTRL, (32'h8 | 32'(k)) << (8 * d));
                @(posedge i_clk);
                #1 chk(32'(o_div_clk[d]), 32'h0);
                for (int i = 0; i < 2 * h; i++) begin
                    @(posedge i_clk);
                    #1 chk(32'(o_div_clk[d]), 32'(i < h));
                end
                rd(ccds_pkg::OFS_STATUS, r);
                chk(32'(r[1:0]), 32'(1 << d));
                wr(ccds_pkg::OFS_DIV_CTRL, 32'hC << (8 * d));
                #1 chk(32'(o_div_clk[d]), 32'h0);
                repeat (5) @(posedge i_clk);
                #1 chk(32'(o_div_clk[d]), 32'h0);
                wr(ccds_pkg::OFS_DIV_CTRL, 32'h0);
            end
        end
    endtask
    task automatic t_route();
        logic [31:0] r;
        wr(8'h18, 32'h0054_3210);
        wr(8'h1C, 32'h0000_6776);
        repeat (30) @(posedge i_clk);
        for (int l = 0; l < 6; l++) follow(8 + l, l, 1, 12);
        follow(14, 6, 2, 16);
        follow(15, 7, 2, 16);
        wr(ccds_pkg::OFS_SEL_CTRL, 32'h4);
        repeat (40) @(posedge i_clk);
        follow(14, 7, 2, 20);
        follow(15, 7, 2, 8);
        rd(ccds_pkg::OFS_STATUS, r);
        chk(32'(r[15:8]), 32'h4);
        rd(8'h18, r);
        chk(r, 32'h0054_3210);
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_regs();
        t_gate();
        t_div();
        t_route();
        summarize();
    end
endmodule
